// ---- rtl/timer_pkg.sv ----
package timer_pkg;
	// ***********************************
	// Register map (byte addresses)
	// ***********************************
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] COUNT_OFS  = 8'h04;
	localparam logic [7:0] PERIOD_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0c;
	localparam logic [7:0] MASK_OFS   = 8'h10;
	localparam logic [7:0] CONFIG_OFS = 8'h14;

	// ***********************************
	// Control register fields
	// ***********************************
	localparam int TIMER_ON_BIT   = 15;
	localparam int IDLE_STOP_BIT  = 13;
	localparam int GATE_EN_BIT    = 6;
	localparam int PRESCALE_LO    = 4;
	localparam int PAIR_WIDE_BIT  = 3;
	localparam int CLK_SOURCE_BIT = 1;
	localparam logic [15:0] CTRL_IMPL_MASK = 16'ha07a;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;

	// ***********************************
	// Config, status and mask fields
	// ***********************************
	localparam int EXT_SYNC_BIT = 0;
	localparam int PRIO_LO      = 1;
	localparam int PRIO_HI      = 3;
	localparam logic [3:0] CONFIG_RESET = 4'h0;
	localparam int MATCH_BIT    = 0;
	localparam int GATE_BIT     = 1;
	localparam logic [1:0] STATUS_RESET = 2'h0;
	localparam logic [1:0] MASK_RESET   = 2'h0;

	// ***********************************
	// Prescaler terminal counts (ratio - 1)
	// ***********************************
	localparam logic [7:0] DIV1_LAST   = 8'h00;
	localparam logic [7:0] DIV8_LAST   = 8'h07;
	localparam logic [7:0] DIV64_LAST  = 8'h3f;
	localparam logic [7:0] DIV256_LAST = 8'hff;
	localparam logic [31:0] PERIOD_RESET = 32'hffffffff;
endpackage

// ---- rtl/count_prescaler.sv ----
`timescale 1ns/100ps
module count_prescaler
	import timer_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       clear,
	input  wire logic       tick_in,
	input  wire logic [1:0] prescale_select,
	output logic            tick_out
);
	logic [7:0] div_count;
	logic [7:0] last;

	always_comb begin
		case (prescale_select)
			2'h0:    last = DIV1_LAST;
			2'h1:    last = DIV8_LAST;
			2'h2:    last = DIV64_LAST;
			default: last = DIV256_LAST;
		endcase
	end

	assign tick_out = tick_in && (div_count == last);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_count <= 8'h00;
		end else if (clear || tick_out) begin
			div_count <= 8'h00;
		end else if (tick_in) begin
			div_count <= div_count + 8'h01;
		end
	end

	// Ratio changes only through a control write, which also clears the divider
	ps_ratio_a: assert property (@(posedge pclk) disable iff (!presetn)
		div_count <= last)
		else $error("prescaler ran past its terminal count");
endmodule // count_prescaler

// ---- rtl/gated_prescaled_timer.sv ----
// Notes on behaviour
// - Sixteen-bit up counter, interval or event use.
// - Timer, synchronous counter, asynchronous counter modes.
// - Keeps counting in Idle unless the idle-stop bit is set; in Sleep only as asynchronous counter.
// - Interrupt on period match or gate fall.
// - Timer-on bit starts and stops counting.
// - Two-bit field selects prescale ratio.
// - Clock source bit; gate-enable bit accumulates.
// - Sync bit chooses synchronised or asynchronous counting.
// - Counter compared with writable period register.
// - Interrupt forwarded when enabled, three-bit priority.
// - Gate enable ignored with external clock.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module gated_prescaled_timer
	import timer_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_clock_pin,
	input  wire logic        core_idle,
	input  wire logic        core_sleep,
	output logic             timer_irq,
	output logic [2:0]       timer_irq_priority
);
	// ***********************************
	// Registers and state
	// ***********************************
	logic [15:0] timer_control;
	logic [31:0] count;
	logic [31:0] period_value;
	logic [1:0]  irq_status;
	logic [1:0]  irq_mask;
	logic [3:0]  timer_config;
	logic        pin_meta;
	logic        pin_sync;
	logic        pin_last;

	logic        timer_on;
	logic        idle_stop;
	logic        gate_accumulate_enable;
	logic [1:0]  prescale_select;
	logic        pair_wide_mode;
	logic        clock_source_select;
	logic        external_sync_select;
	logic        access_phase;
	logic        wr_ctrl;
	logic        wr_count;
	logic        wr_period;
	logic        wr_status;
	logic        wr_mask;
	logic        wr_config;
	logic        pin_rise;
	logic        pin_fall;
	logic        gated_mode;
	logic        running;
	logic        raw_tick;
	logic        count_tick;
	logic        match_now;
	logic        gate_event;
	logic [31:0] next_count;
	logic [31:0] read_value;
	logic        read_hit;

	// ***********************************
	// Field decode
	// ***********************************
	assign timer_on               = timer_control[TIMER_ON_BIT];
	assign idle_stop              = timer_control[IDLE_STOP_BIT];
	assign gate_accumulate_enable = timer_control[GATE_EN_BIT];
	assign prescale_select        = timer_control[PRESCALE_LO +: 2];
	assign pair_wide_mode         = timer_control[PAIR_WIDE_BIT];
	assign clock_source_select    = timer_control[CLK_SOURCE_BIT];
	assign external_sync_select   = timer_config[EXT_SYNC_BIT];

	function automatic logic hit(input logic [7:0] ofs);
		hit = access_phase && pwrite && (paddr == ofs);
	endfunction

	assign access_phase = psel && penable && pready;
	assign wr_ctrl      = hit(CTRL_OFS);
	assign wr_count     = hit(COUNT_OFS);
	assign wr_period    = hit(PERIOD_OFS);
	assign wr_status    = hit(STATUS_OFS);
	assign wr_mask      = hit(MASK_OFS);
	assign wr_config    = hit(CONFIG_OFS);

	// ***********************************
	// Pin synchroniser
	// ***********************************
	// The pin serves as count clock or gate. Both counter modes see it
	// through the same two flops; the asynchronous mode differs only in
	// that it keeps counting while the core sleeps.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_last <= 1'b0;
		end else begin
			pin_meta <= ext_clock_pin;
			pin_sync <= pin_meta;
			pin_last <= pin_sync;
		end
	end

	assign pin_rise = pin_sync && !pin_last;
	assign pin_fall = !pin_sync && pin_last;

	// ***********************************
	// Count source and run control
	// ***********************************
	assign gated_mode = gate_accumulate_enable && !clock_source_select;

	always_comb begin
		if (clock_source_select) begin
			raw_tick = pin_rise;
		end else if (gated_mode) begin
			raw_tick = pin_sync;
		end else begin
			raw_tick = 1'b1;
		end
	end

	// Sleep stops the internal clock, so only the asynchronous counter
	// carries on there; Idle obeys the idle-stop bit.
	always_comb begin
		running = timer_on;
		if (core_idle && idle_stop) begin
			running = 1'b0;
		end
		if (core_sleep && !(clock_source_select && !external_sync_select)) begin
			running = 1'b0;
		end
	end

	count_prescaler u_prescaler (
		.pclk            (pclk),
		.presetn         (presetn),
		.clear           (wr_ctrl || !timer_on),
		.tick_in         (raw_tick && running),
		.prescale_select (prescale_select),
		.tick_out        (count_tick)
	);

	// ***********************************
	// Counter and period match
	// ***********************************
	always_comb begin
		if (pair_wide_mode) begin
			match_now  = (count == period_value);
			next_count = count + 32'h1;
		end else begin
			match_now  = (count[15:0] == period_value[15:0]);
			next_count = {16'h0, count[15:0] + 16'h1};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 32'h0;
		end else if (wr_count) begin
			count <= pair_wide_mode ? pwdata : {16'h0, pwdata[15:0]};
		end else if (count_tick) begin
			count <= match_now ? 32'h0 : next_count;
		end else if (!pair_wide_mode) begin
			count[31:16] <= 16'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_value <= PERIOD_RESET;
		end else if (wr_period) begin
			period_value <= pwdata;
		end
	end

	// ***********************************
	// Control and config registers
	// ***********************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control <= CTRL_RESET;
		end else if (wr_ctrl) begin
			timer_control <= pwdata[15:0] & CTRL_IMPL_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_config <= CONFIG_RESET;
		end else if (wr_config) begin
			timer_config <= pwdata[3:0];
		end
	end

	// ***********************************
	// Interrupt status, mask and output
	// ***********************************
	// A gate fall ends an accumulation window; only counted while running.
	assign gate_event = gated_mode && running && pin_fall;

	// Hardware set wins over a same-cycle write-one clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= STATUS_RESET;
		end else begin
			irq_status[MATCH_BIT] <= (count_tick && match_now)
				|| (irq_status[MATCH_BIT] && !(wr_status && pwdata[MATCH_BIT]));
			irq_status[GATE_BIT] <= gate_event
				|| (irq_status[GATE_BIT] && !(wr_status && pwdata[GATE_BIT]));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= MASK_RESET;
		end else if (wr_mask) begin
			irq_mask <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_irq          <= 1'b0;
			timer_irq_priority <= 3'h0;
		end else begin
			timer_irq          <= |(irq_status & irq_mask);
			timer_irq_priority <= timer_config[PRIO_HI:PRIO_LO];
		end
	end

	// ***********************************
	// APB slave
	// ***********************************
	// Answer is prepared in the setup cycle so every access finishes
	// in its first access cycle with no wait state.
	always_comb begin
		read_hit = 1'b1;
		case (paddr)
			CTRL_OFS:   read_value = {16'h0, timer_control & CTRL_IMPL_MASK};
			COUNT_OFS:  read_value = count;
			PERIOD_OFS: read_value = period_value;
			STATUS_OFS: read_value = {30'h0, irq_status};
			MASK_OFS:   read_value = {30'h0, irq_mask};
			CONFIG_OFS: read_value = {28'h0, timer_config};
			default: begin
				read_value = 32'h0;
				read_hit   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !read_hit;
			prdata  <= (psel && !penable && !pwrite) ? read_value : 32'h0;
		end
	end

	// ***********************************
	// Checks
	// ***********************************
	off_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!timer_on && !wr_count && !$past(wr_ctrl) |=> $stable(count[15:0]))
		else $error("counter moved while timer was off");

	idle_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		core_idle && idle_stop && !wr_count |=> $stable(count[15:0]))
		else $error("counter moved in idle with idle stop set");

	match_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
		count_tick && match_now && !wr_count |=> count == 32'h0)
		else $error("counter did not clear after period match");

	match_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		count_tick && match_now |=> irq_status[MATCH_BIT] ##1 $past(irq_status[MATCH_BIT]))
		else $error("period match did not set its flag");

	gate_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(irq_status[GATE_BIT]) |-> $past(!clock_source_select && pin_fall))
		else $error("gate flag set without an internal-clock gate fall");

	irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		|(irq_status & irq_mask) |=> timer_irq ##1 1'b1)
		else $error("unmasked status did not raise the interrupt");

	irq_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
		(irq_status & irq_mask) == 2'h0 |=> !timer_irq)
		else $error("interrupt raised with nothing unmasked");

	ctrl_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
		(timer_control & ~CTRL_IMPL_MASK) == 16'h0)
		else $error("unimplemented control bit held a one");

	narrow_top_a: assert property (@(posedge pclk) disable iff (!presetn)
		!pair_wide_mode && !wr_ctrl [*2] |=> count[31:16] == 16'h0)
		else $error("upper count half live in 16-bit mode");
endmodule // gated_prescaled_timer

// ---- sim/gated_prescaled_timer_tb_top.sv ----
`timescale 1ns/100ps
module gated_prescaled_timer_tb_top;
	import timer_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ext_clock_pin;
	logic        core_idle;
	logic        core_sleep;
	logic        timer_irq;
	logic [2:0]  timer_irq_priority;
	logic [31:0] rdata;
	logic        rerr;
	logic [31:0] k;
	logic [2:0]  prio;
	int          mismatches;
	int          n_checks;
	int          cyc;

	gated_prescaled_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_clock_pin(ext_clock_pin), .core_idle(core_idle),
		.core_sleep(core_sleep), .timer_irq(timer_irq), .timer_irq_priority(timer_irq_priority));

	// ***********************************
	// Clock, checks and closing
	// ***********************************
	always #5 pclk = ~pclk;

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Cut a hang short well above the expected run length
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches++;
			$display("[FAIL] %0t run timed out", $time);
			close_out();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] ctrl_exp(input logic [31:0] w);
		return {16'h0000, w[15:0] & CTRL_IMPL_MASK};
	endfunction

	function automatic logic [31:0] ratio(input logic [1:0] ps);
		return (ps == 2'd0) ? 32'd1 : (ps == 2'd1) ? 32'd8 : (ps == 2'd2) ? 32'd64 : 32'd256;
	endfunction

	function automatic logic [31:0] inside_rng(input logic [31:0] v, lo, hi);
		return {31'h0, (v >= lo) && (v <= hi)};
	endfunction

	// ***********************************
	// Bus and pin drivers
	// ***********************************
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for the slave
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge pclk);
			ext_clock_pin <= 1'b1;
			repeat (4) @(posedge pclk);
			ext_clock_pin <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		repeat (8) @(posedge pclk);
	endtask

	// ***********************************
	// Main sequence
	// ***********************************
	initial begin
		pclk = 0;
		presetn = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{ext_clock_pin, core_idle, core_sleep} = '0;
		mismatches = 0;
		n_checks = 0;
		cyc = 0;
		void'($urandom(57));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(CTRL_OFS);   chk(rdata, 32'h0);
		rd(PERIOD_OFS); chk(rdata, PERIOD_RESET);
		rd(STATUS_OFS); chk(rdata, 32'h0);
		wr(CTRL_OFS, 32'h5f85);
		rd(CTRL_OFS); chk(rdata, ctrl_exp(32'h5f85));
		k = $urandom & 32'h7fff;
		wr(CTRL_OFS, k);
		rd(CTRL_OFS); chk(rdata, ctrl_exp(k));
		chk({31'h0, rerr}, 32'h0);
		wr(CTRL_OFS, 32'h0);
		wr(8'h20, 32'h1); chk({31'h0, rerr}, 32'h1);
		rd(8'h20); chk({31'h0, rerr}, 32'h1);
		k = $urandom;
		wr(COUNT_OFS, k);
		rd(COUNT_OFS); chk(rdata, {16'h0, k[15:0]});
		// Prescale ratios; bus overhead allows a few extra ticks at 1:1
		for (int ps = 0; ps < 4; ps++) begin
			k = 32'd2 + ($urandom % 4);
			wr(COUNT_OFS, 32'h0);
			wr(CTRL_OFS, 32'h8000 | (ps << PRESCALE_LO));
			repeat (k * ratio(ps[1:0])) @(posedge pclk);
			wr(CTRL_OFS, ps << PRESCALE_LO);
			rd(COUNT_OFS); chk(inside_rng(rdata, k - 1, k + 4), 32'h1);
			k = rdata;
			repeat (10) @(posedge pclk);
			rd(COUNT_OFS); chk(rdata, k);
		end
		// Period match and interrupt path
		wr(PERIOD_OFS, 32'h2);
		wr(COUNT_OFS, 32'h0);
		wr(CTRL_OFS, 32'h8000);
		repeat (20) @(posedge pclk);
		rd(COUNT_OFS); chk(inside_rng(rdata, 0, 2), 32'h1);
		wr(CTRL_OFS, 32'h0);
		rd(STATUS_OFS); chk(rdata, 32'h1);
		chk({31'h0, timer_irq}, 32'h0);
		wr(MASK_OFS, 32'h1);
		repeat (2) @(posedge pclk);
		chk({31'h0, timer_irq}, 32'h1);
		wr(STATUS_OFS, 32'h1);
		repeat (2) @(posedge pclk);
		chk({31'h0, timer_irq}, 32'h0);
		prio = 3'($urandom);
		wr(CONFIG_OFS, {28'h0, prio, 1'b0});
		repeat (2) @(posedge pclk);
		chk({29'h0, timer_irq_priority}, {29'h0, prio});
		// Idle handling
		wr(PERIOD_OFS, PERIOD_RESET);
		wr(COUNT_OFS, 32'h0);
		core_idle <= 1'b1;
		wr(CTRL_OFS, 32'ha000);
		repeat (50) @(posedge pclk);
		rd(COUNT_OFS); chk(rdata, 32'h0);
		wr(CTRL_OFS, 32'h8000);
		repeat (50) @(posedge pclk);
		wr(CTRL_OFS, 32'h0);
		rd(COUNT_OFS); chk(inside_rng(rdata, 50, 60), 32'h1);
		core_idle <= 1'b0;
		// External clock, gate bit ignored there
		k = 32'd3 + ($urandom % 8);
		wr(COUNT_OFS, 32'h0);
		wr(CONFIG_OFS, 32'h1);
		wr(CTRL_OFS, 32'h8042);
		pulses(k);
		rd(COUNT_OFS); chk(rdata, k);
		core_sleep <= 1'b1;
		pulses(k);
		rd(COUNT_OFS); chk(rdata, k);
		wr(CONFIG_OFS, 32'h0);
		pulses(k);
		rd(COUNT_OFS); chk(rdata, 2 * k);
		core_sleep <= 1'b0;
		// Gated accumulation and gate fall event
		wr(CTRL_OFS, 32'h0);
		wr(STATUS_OFS, 32'h3);
		wr(COUNT_OFS, 32'h0);
		wr(CTRL_OFS, 32'h8040);
		k = 32'd20 + ($urandom % 20);
		@(posedge pclk);
		ext_clock_pin <= 1'b1;
		repeat (k) @(posedge pclk);
		ext_clock_pin <= 1'b0;
		repeat (8) @(posedge pclk);
		rd(COUNT_OFS); chk(inside_rng(rdata, k - 2, k + 2), 32'h1);
		rd(STATUS_OFS); chk(rdata & 32'h2, 32'h2);
		// Wide pairing against plain 16-bit wrap
		wr(CTRL_OFS, 32'h0);
		wr(COUNT_OFS, 32'hfffe);
		wr(CTRL_OFS, 32'h8008);
		repeat (20) @(posedge pclk);
		wr(CTRL_OFS, 32'h0008);
		rd(COUNT_OFS); chk(inside_rng(rdata, 32'h10000, 32'h10020), 32'h1);
		wr(CTRL_OFS, 32'h0);
		wr(COUNT_OFS, 32'hfffe);
		wr(CTRL_OFS, 32'h8000);
		repeat (20) @(posedge pclk);
		wr(CTRL_OFS, 32'h0);
		rd(COUNT_OFS); chk(inside_rng(rdata, 0, 32'h20), 32'h1);
		close_out();
	end
endmodule // gated_prescaled_timer_tb_top
